//--- shared/ddscfg_pkg.sv
/*
 * Package for the stream-side input logic of a direct digital synthesizer:
 * widths, field positions, reset values and the payload structs.
 * Assumes a single clock domain and a fixed build of four channels with 11-bit phase.
 */
package ddscfg_pkg;

    // ------------------------------------------------------------------
    // Build constants
    // ------------------------------------------------------------------
    localparam int          DDSC_CHANNELS   = 4;
    localparam int          DDSC_CHAN_W     = 2;
    localparam int          DDSC_PHASE_W    = 11;
    localparam int          DDSC_FIELD_W    = 16;
    localparam int          DDSC_CFG_W      = 32;
    localparam int          DDSC_PH_W       = 32;
    localparam int          DDSC_LUT_W      = 16;
    localparam int          DDSC_INC_LSB    = 0;
    localparam int          DDSC_OFF_LSB    = 16;
    localparam int          DDSC_LUT_LSB    = 0;
    localparam logic [1:0]  DDSC_LAST_CHAN  = 2'h3;
    localparam logic [1:0]  DDSC_CHAN_RST   = 2'h0;
    localparam logic [10:0] DDSC_PHASE_RST  = 11'h000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef logic [DDSC_PHASE_W-1:0] ddsc_phase_t;

    typedef struct packed {
        ddsc_phase_t phase_increment;
        ddsc_phase_t phase_offset;
    } ddsc_chan_cfg_t;

    typedef struct packed {
        logic                   valid;
        logic                   last;
        logic [DDSC_CHAN_W-1:0] chan;
        ddsc_phase_t            phase_increment;
        ddsc_phase_t            phase_offset;
        ddsc_phase_t            raw_phase;
    } ddsc_sample_t;

    typedef struct packed {
        logic missing;
        logic unexpected;
    } ddsc_last_evt_t;

endpackage : ddscfg_pkg

//--- rtl/ddsc_last_check.sv
/*
 * Beat counter and last-beat checker for one multiplexed stream channel.
 * Assumes the caller pulses beat_taken for each accepted beat, same clock.
 */
`timescale 1ns/1ns
module ddsc_last_check
    import ddscfg_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   beat_taken,
    input  wire logic                   beat_last,
    output logic [DDSC_CHAN_W-1:0]      chan,
    output logic                        wrap,
    output ddsc_last_evt_t              evt
);

    typedef struct packed {
        logic [DDSC_CHAN_W-1:0] chan;
    } ddsc_chk_state_t;

    ddsc_chk_state_t state_reg;
    ddsc_chk_state_t state_next;
    logic            at_end;

    assign at_end = (state_reg.chan == DDSC_LAST_CHAN);
    assign chan   = state_reg.chan;
    // Combinational so the event shows in the beat's own cycle
    assign wrap   = beat_taken && (at_end || beat_last);
    assign evt.missing    = beat_taken && at_end && !beat_last;
    assign evt.unexpected = beat_taken && !at_end && beat_last;

    always_comb begin
        state_next = state_reg;
        if (beat_taken) begin
            // Any last resyncs to channel 0
            if (at_end || beat_last) begin
                state_next.chan = DDSC_CHAN_RST;
            end else begin
                state_next.chan = state_reg.chan + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule : ddsc_last_check

//--- rtl/ddsc_stream_in.sv
/*
 * Stream-side input logic of a multi-channel direct digital synthesizer:
 * configuration vector capture, pending/apply on a sync event, input phase
 * stream with one-entry output register, last-beat checking and events.
 * Assumes upstream masters and a downstream sink on the same clock.
 */
// Functional notes
// - Datapath channels without ready act as always ready; out_ready tie high then.
// - A beat moves when valid and ready are both high.
// - Output sample held until downstream ready, also after reset.
// - Configuration stream never stalls samples or the phase stream.
// - Last only on beat N-1; otherwise missing/unexpected event pulses.
// - Vector counts only after final beat; held until sync event.
// - Pending vector applies on counter wrap or packet last.
// - Single-channel build has no config last input.
// - Config beat: increment bits 10:0, offset bits 26:16, sign-extended.
// - Output held off drops phase input ready once buffer full.
// - No input phase valid means no output valid.
// - Phase input carries streaming fields or raw LUT phase, never both.
// - Raw phase in low bits of a byte-rounded bus.
// - Padding bits above raw phase ignored.
// - All data passes over valid/data stream channels.
// - Events assert in the cycle of the discrepancy, cleared by reset; here registered, so they show one cycle later.
// - Vector-framed phase last must mark last channel, else event.
`timescale 1ns/1ns
module ddsc_stream_in
    import ddscfg_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Build selections, static straps from the same clock domain
    input  wire logic                   lut_only,
    input  wire logic                   packet_framing,
    input  wire logic                   stream_increment,
    input  wire logic                   stream_offset,
    // Configuration stream
    input  wire logic                   cfg_tvalid,
    output logic                        cfg_tready,
    input  wire logic [DDSC_CFG_W-1:0]  cfg_tdata,
    input  wire logic                   cfg_tlast,
    // Input phase stream
    input  wire logic                   ph_tvalid,
    output logic                        ph_tready,
    input  wire logic [DDSC_PH_W-1:0]   ph_tdata,
    input  wire logic                   ph_tlast,
    // Sample stream to the synthesis core
    output ddsc_sample_t                out_sample,
    input  wire logic                   out_ready,
    // Events
    output logic                        event_cfg_last_missing,
    output logic                        event_cfg_last_unexpected,
    output logic                        event_ph_last_missing,
    output logic                        event_ph_last_unexpected
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        ddsc_chan_cfg_t [DDSC_CHANNELS-1:0] shadow;
        ddsc_chan_cfg_t [DDSC_CHANNELS-1:0] pending;
        ddsc_chan_cfg_t [DDSC_CHANNELS-1:0] active;
        logic                               pend_valid;
        ddsc_sample_t                       out;
        logic                               cfg_rdy;
        ddsc_last_evt_t                     cfg_evt;
        ddsc_last_evt_t                     ph_evt;
    } ddsc_state_t;

    ddsc_state_t    state_reg;
    ddsc_state_t    state_next;

    logic                   cfg_take;
    logic                   ph_take;
    logic                   ph_rdy;
    logic [DDSC_CHAN_W-1:0] cfg_chan;
    logic [DDSC_CHAN_W-1:0] ph_chan;
    logic                   cfg_wrap;
    logic                   ph_wrap;
    ddsc_last_evt_t         cfg_evt_now;
    ddsc_last_evt_t         ph_evt_now;
    logic                   sync_event;
    logic                   cfg_last_eff;
    ddsc_chan_cfg_t         cfg_fields;
    ddsc_chan_cfg_t         ph_fields;

    // ------------------------------------------------------------------
    // Handshakes
    // ------------------------------------------------------------------
    // Config channel accepts from the first clock after reset; never touches the sample path
    assign cfg_take = cfg_tvalid && state_reg.cfg_rdy;
    // Sink without ready: tie out_ready high, ready never drops
    // One-entry skid: ready while the output slot is empty or drains
    assign ph_rdy   = !state_reg.out.valid || out_ready;
    assign ph_take  = ph_tvalid && ph_rdy;
    // Single channel: the lone beat closes the vector by itself
    assign cfg_last_eff = (DDSC_CHANNELS == 1) ? 1'b1 : cfg_tlast;

    // ------------------------------------------------------------------
    // Field unpack
    // ------------------------------------------------------------------
    // Increment low field, offset upper field; sign bits dropped
    assign cfg_fields.phase_increment = cfg_tdata[DDSC_INC_LSB +: DDSC_PHASE_W];
    assign cfg_fields.phase_offset    = cfg_tdata[DDSC_OFF_LSB +: DDSC_PHASE_W];
    // Streamed fields packed as on the config bus
    assign ph_fields.phase_increment  = ph_tdata[DDSC_INC_LSB +: DDSC_PHASE_W];
    assign ph_fields.phase_offset     = ph_tdata[DDSC_OFF_LSB +: DDSC_PHASE_W];

    // ------------------------------------------------------------------
    // Beat counters and last checks
    // ------------------------------------------------------------------
    ddsc_last_check u_cfg_chk (
        .clk        (clk),
        .rst_n      (rst_n),
        .beat_taken (cfg_take),
        .beat_last  (cfg_last_eff),
        .chan       (cfg_chan),
        .wrap       (cfg_wrap),
        .evt        (cfg_evt_now)
    );

    ddsc_last_check u_ph_chk (
        .clk        (clk),
        .rst_n      (rst_n),
        .beat_taken (ph_take),
        .beat_last  (ph_tlast),
        .chan       (ph_chan),
        .wrap       (ph_wrap),
        .evt        (ph_evt_now)
    );

    // ------------------------------------------------------------------
    // Synchronization event
    // ------------------------------------------------------------------
    // Counter rollover, or accepted packet last
    assign sync_event = packet_framing ? (ph_take && ph_tlast) : ph_wrap;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.cfg_rdy = 1'b1;

        // Capture config beat into the shadow slot for its channel
        if (cfg_take) begin
            state_next.shadow[cfg_chan] = cfg_fields;
        end

        // Apply before a new vector completes, so a vector finishing
        // in the sync cycle waits for the next event
        if (sync_event && state_reg.pend_valid) begin
            state_next.active     = state_reg.pending;
            state_next.pend_valid = 1'b0;
        end

        // Vector counts only once its final beat lands
        if (cfg_take && cfg_wrap) begin
            state_next.pending = state_next.shadow;
            state_next.pend_valid = 1'b1;
        end

        // Output slot: hold until downstream takes it
        if (state_reg.out.valid && out_ready) begin
            state_next.out.valid = 1'b0;
        end
        if (ph_take) begin
            state_next.out.valid = 1'b1;
            state_next.out.last  = ph_tlast;
            state_next.out.chan  = ph_chan;
            state_next.out.phase_increment = state_reg.active[ph_chan].phase_increment;
            state_next.out.phase_offset    = state_reg.active[ph_chan].phase_offset;
            state_next.out.raw_phase       = DDSC_PHASE_RST;
            if (lut_only) begin
                // Padding above the phase field is never read
                state_next.out.raw_phase = ph_tdata[DDSC_LUT_LSB +: DDSC_PHASE_W];
            end else begin
                // Streamed fields packed as on the config bus
                if (stream_increment) begin
                    state_next.out.phase_increment = ph_fields.phase_increment;
                end
                if (stream_offset) begin
                    state_next.out.phase_offset = ph_fields.phase_offset;
                end
            end
        end

        // Events follow the discrepancy, one cycle per occurrence
        state_next.cfg_evt = (DDSC_CHANNELS == 1) ? '0 : cfg_evt_now;
        state_next.ph_evt  = packet_framing ? '0 : ph_evt_now;
    end

    // Sample, config ready and events registered; events therefore trail the beat by one clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign cfg_tready = state_reg.cfg_rdy;
    // Ready stays combinational so one slot runs at full rate
    assign ph_tready  = ph_rdy;
    assign out_sample = state_reg.out;

    // ------------------------------------------------------------------
    // Event outputs
    // ------------------------------------------------------------------
    assign event_cfg_last_missing    = state_reg.cfg_evt.missing;
    assign event_cfg_last_unexpected = state_reg.cfg_evt.unexpected;
    assign event_ph_last_missing     = state_reg.ph_evt.missing;
    assign event_ph_last_unexpected  = state_reg.ph_evt.unexpected;

endmodule : ddsc_stream_in

//--- tb/ddsc_stream_in_props.sv
/* Port checks for ddsc_stream_in.
   Assumes one clock and a bind from the bench. */
`timescale 1ns/1ns
module ddsc_stream_in_props
    import ddscfg_pkg::*;
(
    input wire logic         clk,
    input wire logic         rst_n,
    input wire logic         packet_framing,
    input wire logic         lut_only,
    input wire logic         cfg_tvalid,
    input wire logic         cfg_tready,
    input wire logic         cfg_tlast,
    input wire logic         ph_tvalid,
    input wire logic         ph_tready,
    input wire logic [31:0]  ph_tdata,
    input wire logic         ph_tlast,
    input wire ddsc_sample_t out_sample,
    input wire logic         out_ready,
    input wire logic         event_cfg_last_missing,
    input wire logic         event_ph_last_missing
);
    // ----------------------------------------
    // Own beat counters, resync on any last
    // ----------------------------------------
    logic [1:0] cc_reg;
    logic [1:0] pc_reg;
    wire c_tk = cfg_tvalid && cfg_tready;
    wire p_tk = ph_tvalid && ph_tready;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cc_reg <= 2'h0;
            pc_reg <= 2'h0;
        end else begin
            if (c_tk) cc_reg <= cfg_tlast ? 2'h0 : cc_reg + 2'h1;
            if (p_tk) pc_reg <= ph_tlast ? 2'h0 : pc_reg + 2'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ph_rdy_a: assert property (ph_tready == (!out_sample.valid || out_ready))
        else $error("phase ready wrong");
    sample_hold_a: assert property (out_sample.valid && !out_ready |=> $stable(out_sample))
        else $error("sample not held");
    take_valid_a: assert property (p_tk |=> out_sample.valid)
        else $error("taken beat lost");
    starve_valid_a: assert property (!ph_tvalid && ph_tready |=> !out_sample.valid)
        else $error("valid without input");
    cfg_rdy_a: assert property ($past(rst_n) |-> cfg_tready)
        else $error("config stalled");
    cfg_miss_a: assert property (
        event_cfg_last_missing == $past(c_tk && !cfg_tlast && cc_reg == 2'h3))
        else $error("config missing event wrong");
    ph_miss_a: assert property (!packet_framing |->
        event_ph_last_missing == $past(p_tk && !ph_tlast && pc_reg == 2'h3))
        else $error("phase missing event wrong");
    raw_phase_a: assert property (p_tk && lut_only |=> out_sample.raw_phase == $past(ph_tdata[10:0]))
        else $error("raw phase wrong");
endmodule : ddsc_stream_in_props

//--- tb/ddsc_sink_model.sv
/* Downstream sink: ready low while told to stall.
   Assumes the block's clock and reset. */
`timescale 1ns/1ns
module ddsc_sink_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stall,
    output logic     ready
);
    // Not ready out of reset; ready follows stall from the first clock, the earliest a sample can be valid
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) ready <= 1'b0;
        else ready <= !stall;
    end
endmodule : ddsc_sink_model

//--- tb/tb.sv
/* Bench for ddsc_stream_in with the sink model.
   Assumes checker and sink compiled first. */
`timescale 1ns/1ns
module tb
    import ddscfg_pkg::*;
;
    logic clk, rst_n, lut_only, packet_framing, stream_increment, stream_offset, stall;
    logic cfg_tvalid, cfg_tready, cfg_tlast, ph_tvalid, ph_tready, ph_tlast, out_ready, ecm, ecu, epm, epu;
    logic [31:0] cfg_tdata, ph_tdata;
    ddsc_sample_t out_sample;
    int fails, n_compared;
    ddsc_stream_in u_ddsc_stream_in (.clk(clk), .rst_n(rst_n), .lut_only(lut_only),
        .packet_framing(packet_framing), .stream_increment(stream_increment), .stream_offset(stream_offset),
        .cfg_tvalid(cfg_tvalid), .cfg_tready(cfg_tready), .cfg_tdata(cfg_tdata), .cfg_tlast(cfg_tlast),
        .ph_tvalid(ph_tvalid), .ph_tready(ph_tready), .ph_tdata(ph_tdata), .ph_tlast(ph_tlast),
        .out_sample(out_sample), .out_ready(out_ready), .event_cfg_last_missing(ecm),
        .event_cfg_last_unexpected(ecu), .event_ph_last_missing(epm), .event_ph_last_unexpected(epu));
    ddsc_sink_model u_ddsc_sink_model (.clk(clk), .rst_n(rst_n), .stall(stall), .ready(out_ready));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t %s: %h not %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    // Ready is looked at on the falling edge, after the rising edge settles
    task automatic wait_ph;
        for (int i = 0; ph_tready !== 1'b1; i++) begin
            if (i > 40) begin
                fails++;
                end_sim();
            end
            @(negedge clk);
        end
    endtask : wait_ph
    task automatic cfg_beat(input logic [10:0] inc, off, input logic last, em, eu);
        @(posedge clk);
        cfg_tvalid <= 1'b1;
        cfg_tdata <= {{5{off[10]}}, off, {5{inc[10]}}, inc};
        cfg_tlast <= last;
        @(posedge clk);
        cfg_tvalid <= 1'b0;
        @(negedge clk);
        check(ecm, em, "missing");
        check(ecu, eu, "unexpected");
    endtask : cfg_beat
    task automatic ph_beat(input logic [31:0] d, input logic last);
        @(posedge clk);
        ph_tvalid <= 1'b1;
        ph_tdata <= d;
        ph_tlast <= last;
        @(negedge clk);
        wait_ph();
        @(posedge clk);
        ph_tvalid <= 1'b0;
        @(negedge clk);
    endtask : ph_beat
    task automatic t_apply;
        for (int k = 0; k < 4; k++) cfg_beat(11'h101 + 11'(k), 11'h402 + 11'(k), k == 3, 1'b0, 1'b0);
        for (int k = 0; k < 8; k++) begin
            ph_beat(32'h0, k % 4 == 3);
            check(out_sample.chan, 32'(k % 4), "chan");
            if (k < 3) check(out_sample.phase_increment, 32'h0, "early");
            if (k > 3) check({out_sample.phase_increment, out_sample.phase_offset},
                {11'h101 + 11'(k - 4), 11'h402 + 11'(k - 4)}, "applied");
        end
        $display("apply test done");
    endtask : t_apply
    task automatic t_errors;
        cfg_beat(11'h0, 11'h0, 1'b0, 1'b0, 1'b0);
        cfg_beat(11'h0, 11'h0, 1'b1, 1'b0, 1'b1);
        for (int k = 0; k < 4; k++) cfg_beat(11'h0, 11'h0, 1'b0, k == 3, 1'b0);
        for (int k = 0; k < 4; k++) cfg_beat(11'h0, 11'h0, k == 3, 1'b0, 1'b0);
        for (int k = 0; k < 4; k++) begin
            ph_beat(32'h0, 1'b0);
            check(epm, k == 3, "phase missing");
        end
        ph_beat(32'h0, 1'b1);
        check(epu, 1'b1, "phase unexpected");
        check(out_sample.last, 1'b1, "last carried");
        $display("error test done");
    endtask : t_errors
    task automatic t_fields;
        for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            lut_only <= (m == 0);
            stream_increment <= (m != 0);
            stream_offset <= (m == 1);
            for (int k = 0; k < 4; k++) begin
                ph_beat({5'h15, 11'h2a0 + 11'(k), 5'h0a, 11'h5a0 + 11'(k)}, k == 3);
                if (m == 0) check(out_sample.raw_phase, 11'h5a0 + 11'(k), "raw");
                else check({out_sample.phase_increment, out_sample.phase_offset},
                    {11'h5a0 + 11'(k), (m == 1) ? 11'h2a0 + 11'(k) : 11'h000}, "streamed");
            end
        end
        $display("field test done");
    endtask : t_fields
    task automatic t_stall;
        @(posedge clk);
        {stream_increment, stream_offset, lut_only, stall} <= 4'h3;
        ph_beat(32'h11, 1'b0);
        @(posedge clk);
        ph_tvalid <= 1'b1;
        ph_tdata <= 32'h22;
        repeat (3) @(negedge clk);
        check(ph_tready, 1'b0, "backpressure");
        check(out_sample.raw_phase, 11'h011, "held");
        @(posedge clk);
        stall <= 1'b0;
        @(negedge clk);
        wait_ph();
        @(posedge clk);
        ph_tvalid <= 1'b0;
        @(negedge clk);
        check(out_sample.raw_phase, 11'h022, "next");
        repeat (2) @(negedge clk);
        check(out_sample.valid, 1'b0, "starved");
        ph_beat(32'h0, 1'b0);
        ph_beat(32'h0, 1'b1);
        $display("stall test done");
    endtask : t_stall
    task automatic t_packet;
        @(posedge clk);
        {packet_framing, lut_only} <= 2'h2;
        for (int k = 0; k < 4; k++) cfg_beat(11'h333, 11'h044, k == 3, 1'b0, 1'b0);
        ph_beat(32'h0, 1'b1);
        check(epu, 1'b0, "no event");
        check(out_sample.last, 1'b1, "packet last");
        ph_beat(32'h0, 1'b0);
        check({out_sample.phase_increment, out_sample.phase_offset}, {11'h333, 11'h044}, "packet");
        $display("packet test done");
    endtask : t_packet
    initial begin
        {rst_n, lut_only, packet_framing, stream_increment, stream_offset, stall} = 6'h00;
        {cfg_tvalid, cfg_tlast, ph_tvalid, ph_tlast} = 4'h0;
        cfg_tdata = 32'h0;
        ph_tdata = 32'h0;
        fails = 0;
        n_compared = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        check(cfg_tready, 1'b1, "cfg ready");
        check({ph_tready, out_sample.valid}, 2'h2, "idle");
        t_apply();
        t_errors();
        t_fields();
        t_stall();
        t_packet();
        end_sim();
    end
endmodule : tb
bind ddsc_stream_in ddsc_stream_in_props u_props (.clk(clk), .rst_n(rst_n), .packet_framing(packet_framing),
    .lut_only(lut_only), .cfg_tvalid(cfg_tvalid), .cfg_tready(cfg_tready), .cfg_tlast(cfg_tlast),
    .ph_tvalid(ph_tvalid), .ph_tready(ph_tready), .ph_tdata(ph_tdata), .ph_tlast(ph_tlast),
    .out_sample(out_sample), .out_ready(out_ready), .event_cfg_last_missing(event_cfg_last_missing),
    .event_ph_last_missing(event_ph_last_missing));
